/* File: pdc_top.v */
// Notes on behaviour
// - Reference ratio is ten bits: low byte plus two bits of the next register.
// - Reference divides by N for 3 to 1023, undivided for 0 or 1.
// - Reference divider acts while its enable bit is set; once cleared, bypassed from its next wrap.
// - Divided reference, not the raw input, feeds the phase detector.
// - Output divider divides by 2 to 15, undivided for 0 or 1; resets to four.
// - Feedback prescaler ratio is twelve bits: low byte plus four high bits.
// - Prescaler divides oscillator by 2 to 4095, by one for 0 or 1.
// - Prescaler resets to 120: low byte 0x78, upper bits zero.
// - Pump bias bit: one self-biases from supply (default), zero uses bandgap.
// - Four-bit pump current field, about 25 uA per step, resets to two.
// - Loop runs only while its enable bit is set; cleared at reset.
// - Top bit of the enable register reads zero and ignores writes.
// - Converter clock is synthesizer output when source select is one, else input.
`timescale 1ns/1ps
`include "pdc_consts.vh"

module pdc_top (
  input  wire       I_CLK,                  // System clock, 100 MHz.
  input  wire       I_RESET,                // Synchronous reset, active high.
  input  wire       I_REG_WE,               // Register write strobe.
  input  wire       I_REG_RE,               // Register read strobe.
  input  wire [7:0] I_REG_ADDR,             // Register address.
  input  wire [7:0] I_REG_WDATA,            // Register write data.
  output reg  [7:0] O_REG_RDATA,            // Register read data.
  input  wire       I_REF_CLK,              // External reference clock pin.
  input  wire       I_VCO_CLK,              // Oscillator clock.
  input  wire       I_TIMING_SRC_PLL,       // Timing source select, one picks synthesizer.
  output reg        O_PFD_REF_CLK,          // Reference side of the phase detector.
  output reg        O_PFD_FB_CLK,           // Feedback side of the phase detector.
  output reg        O_PLL_OUT_CLK,          // Divided synthesizer output.
  output reg        O_CONV_CLK,             // Converter timing clock.
  output reg        O_LOOP_ENABLE,          // Synthesizer loop enable.
  output reg        O_PUMP_BIAS_SELF,       // Pump self-bias select.
  output reg  [3:0] O_PUMP_CURRENT_LEVEL,   // Pump current code.
  output reg  [7:0] O_FACTORY_BITS_ENABLE   // Raw enable register, factory bits included.
);

  // Register storage; factory bits are stored as plain read-write bits.
  reg  [7:0]  reg_ref_low;
  reg  [7:0]  reg_out_ref_high;
  reg  [7:0]  reg_pre_low;
  reg  [7:0]  reg_pre_high;
  reg  [7:0]  reg_pump;
  reg  [7:0]  reg_enable;

  wire [2:0]  wr_idx;
  wire [2:0]  rd_idx;
  wire        ref_level;
  wire        ref_rise;
  wire        vco_level;
  wire        vco_rise;
  wire [9:0]  ref_clock_divider;
  wire [9:0]  ref_ratio;
  wire [11:0] fb_ratio;
  wire [3:0]  vco_output_divider;
  wire        ref_divider_enable;
  wire        div_ref_clk;
  wire        div_fb_clk;
  wire        div_out_clk;

  // Maps a bus address to a register index; unmapped addresses give the none code.
  function [2:0] reg_index;
    input [7:0] addr;
    begin
      if (addr == `PDC_ADDR_REF_LOW) begin
        reg_index = `PDC_IDX_REF_LOW;
      end else if (addr == `PDC_ADDR_OUT_REF_HIGH) begin
        reg_index = `PDC_IDX_OUT_REF_HIGH;
      end else if (addr == `PDC_ADDR_PRE_LOW) begin
        reg_index = `PDC_IDX_PRE_LOW;
      end else if (addr == `PDC_ADDR_PRE_HIGH) begin
        reg_index = `PDC_IDX_PRE_HIGH;
      end else if (addr == `PDC_ADDR_PUMP) begin
        reg_index = `PDC_IDX_PUMP;
      end else if (addr == `PDC_ADDR_ENABLE) begin
        reg_index = `PDC_IDX_ENABLE;
      end else begin
        reg_index = `PDC_IDX_NONE;
      end
    end
  endfunction

  assign wr_idx = reg_index(I_REG_ADDR);
  assign rd_idx = reg_index(I_REG_ADDR);

  // Register writes; a write to an unmapped address is simply dropped.
  always @(posedge I_CLK) begin
    if (I_RESET) begin
      reg_ref_low      <= `PDC_RST_REF_LOW;
      reg_out_ref_high <= `PDC_RST_OUT_REF_HIGH;
      reg_pre_low      <= `PDC_RST_PRE_LOW;
      reg_pre_high     <= `PDC_RST_PRE_HIGH;
      reg_pump         <= `PDC_RST_PUMP;
      reg_enable       <= `PDC_RST_ENABLE;
    end else if (I_REG_WE) begin
      if (wr_idx == `PDC_IDX_REF_LOW) begin
        reg_ref_low <= I_REG_WDATA;
      end else if (wr_idx == `PDC_IDX_OUT_REF_HIGH) begin
        reg_out_ref_high <= I_REG_WDATA;
      end else if (wr_idx == `PDC_IDX_PRE_LOW) begin
        reg_pre_low <= I_REG_WDATA;
      end else if (wr_idx == `PDC_IDX_PRE_HIGH) begin
        reg_pre_high <= I_REG_WDATA;
      end else if (wr_idx == `PDC_IDX_PUMP) begin
        reg_pump <= I_REG_WDATA;
      end else if (wr_idx == `PDC_IDX_ENABLE) begin
        reg_enable <= I_REG_WDATA & `PDC_ENABLE_WMASK;
      end
    end
  end

  // Read data is registered and returned one cycle after the read strobe.
  // Unmapped addresses read as zero so software sees a defined value.
  always @(posedge I_CLK) begin
    if (I_RESET) begin
      O_REG_RDATA <= 8'h00;
    end else if (I_REG_RE) begin
      if (rd_idx == `PDC_IDX_REF_LOW) begin
        O_REG_RDATA <= reg_ref_low;
      end else if (rd_idx == `PDC_IDX_OUT_REF_HIGH) begin
        O_REG_RDATA <= reg_out_ref_high;
      end else if (rd_idx == `PDC_IDX_PRE_LOW) begin
        O_REG_RDATA <= reg_pre_low;
      end else if (rd_idx == `PDC_IDX_PRE_HIGH) begin
        O_REG_RDATA <= reg_pre_high;
      end else if (rd_idx == `PDC_IDX_PUMP) begin
        O_REG_RDATA <= reg_pump;
      end else if (rd_idx == `PDC_IDX_ENABLE) begin
        O_REG_RDATA <= reg_enable & `PDC_ENABLE_WMASK;
      end else begin
        O_REG_RDATA <= 8'h00;
      end
    end
  end

  // Ratio assembly from the split register fields.
  assign ref_clock_divider  = {reg_out_ref_high[`PDC_REFHI_MSB:`PDC_REFHI_LSB], reg_ref_low};
  assign fb_ratio           = {reg_pre_high[`PDC_PREHI_MSB:`PDC_PREHI_LSB], reg_pre_low};
  assign vco_output_divider = reg_out_ref_high[`PDC_OUTDIV_MSB:`PDC_OUTDIV_LSB];
  assign ref_divider_enable = reg_enable[`PDC_REFDIV_EN_BIT];

  // A disabled reference divider is fed ratio zero, which the divider passes straight through.
  // The unsupported ratio two is treated as undivided rather than left undefined.
  assign ref_ratio = !ref_divider_enable ? 10'h000 :
                     (ref_clock_divider == `PDC_REF_BAD_RATIO) ? `PDC_REF_BAD_SUBST :
                     ref_clock_divider;

  // Both clock pins are asynchronous to I_CLK and are synchronised before use.
  // Sampling limits each source to well below half of I_CLK.
  pdc_edge_sync u_ref_sync (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_pin   (I_REF_CLK),
    .o_level (ref_level),
    .o_rise  (ref_rise)
  );

  pdc_edge_sync u_vco_sync (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_pin   (I_VCO_CLK),
    .o_level (vco_level),
    .o_rise  (vco_rise)
  );

  // Reference divider sits between the input pin and the phase detector.
  pdc_divider #(
    .W (10)
  ) u_ref_div (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_edge  (ref_rise),
    .i_level (ref_level),
    .i_ratio (ref_ratio),
    .o_clk   (div_ref_clk)
  );

  // Feedback prescaler divides the oscillator for the detector's second input.
  pdc_divider #(
    .W (12)
  ) u_fb_div (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_edge  (vco_rise),
    .i_level (vco_level),
    .i_ratio (fb_ratio),
    .o_clk   (div_fb_clk)
  );

  // Output divider produces the synthesizer clock from the oscillator.
  pdc_divider #(
    .W (4)
  ) u_out_div (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_edge  (vco_rise),
    .i_level (vco_level),
    .i_ratio (vco_output_divider),
    .o_clk   (div_out_clk)
  );

  // Output stage; the synthesizer clocks are held low while the loop is off.
  always @(posedge I_CLK) begin
    if (I_RESET) begin
      O_PFD_REF_CLK         <= 1'b0;
      O_PFD_FB_CLK          <= 1'b0;
      O_PLL_OUT_CLK         <= 1'b0;
      O_CONV_CLK            <= 1'b0;
      O_LOOP_ENABLE         <= 1'b0;
      O_PUMP_BIAS_SELF      <= 1'b1;
      O_PUMP_CURRENT_LEVEL  <= 4'h2;
      O_FACTORY_BITS_ENABLE <= `PDC_RST_ENABLE;
    end else begin
      O_PFD_REF_CLK         <= reg_enable[`PDC_LOOP_EN_BIT] & div_ref_clk;
      O_PFD_FB_CLK          <= reg_enable[`PDC_LOOP_EN_BIT] & div_fb_clk;
      O_PLL_OUT_CLK         <= reg_enable[`PDC_LOOP_EN_BIT] & div_out_clk;
      O_CONV_CLK            <= I_TIMING_SRC_PLL ?
                               (reg_enable[`PDC_LOOP_EN_BIT] & div_out_clk) :
                               ref_level;
      O_LOOP_ENABLE         <= reg_enable[`PDC_LOOP_EN_BIT];
      O_PUMP_BIAS_SELF      <= reg_pump[`PDC_PUMP_BIAS_BIT];
      O_PUMP_CURRENT_LEVEL  <= reg_pump[`PDC_PUMP_LEVEL_MSB:`PDC_PUMP_LEVEL_LSB];
      O_FACTORY_BITS_ENABLE <= reg_enable & `PDC_ENABLE_WMASK;
    end
  end

endmodule // pdc_top

/* File: pdc_consts.vh */
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH

// Register addresses on the control port.
`define PDC_ADDR_REF_LOW      8'h54
`define PDC_ADDR_OUT_REF_HIGH 8'h55
`define PDC_ADDR_PRE_LOW      8'h56
`define PDC_ADDR_PRE_HIGH     8'h57
`define PDC_ADDR_PUMP         8'h58
`define PDC_ADDR_ENABLE       8'h59

// Power-on values of the six registers.
`define PDC_RST_REF_LOW       8'h00
`define PDC_RST_OUT_REF_HIGH  8'h48
`define PDC_RST_PRE_LOW       8'h78
`define PDC_RST_PRE_HIGH      8'h40
`define PDC_RST_PUMP          8'h12
`define PDC_RST_ENABLE        8'h41

// Field positions.
`define PDC_OUTDIV_MSB        7
`define PDC_OUTDIV_LSB        4
`define PDC_REFHI_MSB         1
`define PDC_REFHI_LSB         0
`define PDC_PREHI_MSB         3
`define PDC_PREHI_LSB         0
`define PDC_PUMP_BIAS_BIT     4
`define PDC_PUMP_LEVEL_MSB    3
`define PDC_PUMP_LEVEL_LSB    0
`define PDC_REFDIV_EN_BIT     4
`define PDC_LOOP_EN_BIT       1
`define PDC_UNUSED_BIT        7

// Write mask of the enable register: the unused top bit never stores.
`define PDC_ENABLE_WMASK      8'h7f

// Reference ratio that is not supported and the ratio used instead.
`define PDC_REF_BAD_RATIO     10'h002
`define PDC_REF_BAD_SUBST     10'h001

// Register index codes used by the address decoder.
`define PDC_IDX_REF_LOW       3'h0
`define PDC_IDX_OUT_REF_HIGH  3'h1
`define PDC_IDX_PRE_LOW       3'h2
`define PDC_IDX_PRE_HIGH      3'h3
`define PDC_IDX_PUMP          3'h4
`define PDC_IDX_ENABLE        3'h5
`define PDC_IDX_NONE          3'h7

`endif

/* File: pdc_edge_sync.v */
`timescale 1ns/1ps

// Brings an outside clock pin into the I_CLK domain and marks its rising edges.
module pdc_edge_sync (
  input  wire i_clk,    // System clock.
  input  wire i_reset,  // Synchronous reset, active high.
  input  wire i_pin,    // Asynchronous clock pin.
  output wire o_level,  // Synchronised level.
  output wire o_rise    // One-cycle pulse per rising edge.
);

  reg meta;
  reg stable;
  reg delayed;

  // The first stage feeds only the second stage, so no logic sees a metastable value.
  always @(posedge i_clk) begin
    if (i_reset) begin
      meta    <= 1'b0;
      stable  <= 1'b0;
      delayed <= 1'b0;
    end else begin
      meta    <= i_pin;
      stable  <= meta;
      delayed <= stable;
    end
  end

  // Edge detection looks only at the settled stages.
  assign o_level = stable;
  assign o_rise  = stable & ~delayed;

endmodule // pdc_edge_sync

/* File: pdc_divider.v */
`timescale 1ns/1ps

// Integer clock divider counting rising edges of a sampled source clock.
module pdc_divider #(
  parameter W = 4
) (
  input  wire         i_clk,    // System clock.
  input  wire         i_reset,  // Synchronous reset, active high.
  input  wire         i_edge,   // Rising-edge pulse of the source clock.
  input  wire         i_level,  // Synchronised level of the source clock.
  input  wire [W-1:0] i_ratio,  // Requested ratio; 0 and 1 mean undivided.
  output reg          o_clk     // Divided clock level.
);

  localparam [W-1:0] ONE = 1;

  reg  [W-1:0] active;
  reg  [W-1:0] cnt;
  wire         bypass;
  wire [W-1:0] half;
  wire         wrap;

  // Ratios of 0 and 1 pass the source through; the high phase takes the larger half.
  assign bypass = (active <= ONE);
  assign half   = active - (active >> 1);
  assign wrap   = bypass || (cnt == active - ONE);

  // A new ratio is only taken at a wrap, so no output period is ever cut short.
  always @(posedge i_clk) begin
    if (i_reset) begin
      active <= {W{1'b0}};
      cnt    <= {W{1'b0}};
      o_clk  <= 1'b0;
    end else begin
      if (i_edge) begin
        if (wrap) begin
          cnt    <= {W{1'b0}};
          active <= i_ratio;
        end else begin
          cnt <= cnt + ONE;
        end
      end
      o_clk <= bypass ? i_level : (cnt < half);
    end
  end

endmodule // pdc_divider

/* File: pdc_top_asserts.sv */
`timescale 1ns/1ps

// Checks register-driven outputs and clock gating at the top ports.
module pdc_top_asserts (
  input logic       I_CLK,                 // Clock.
  input logic       I_RESET,               // Reset.
  input logic       I_REG_WE,              // Write strobe.
  input logic       I_REG_RE,              // Read strobe.
  input logic [7:0] I_REG_ADDR,            // Address.
  input logic [7:0] I_REG_WDATA,           // Write data.
  input logic [7:0] O_REG_RDATA,           // Read data.
  input logic       I_REF_CLK,             // Reference pin.
  input logic       I_VCO_CLK,             // Oscillator.
  input logic       I_TIMING_SRC_PLL,      // Source select.
  input logic       O_PFD_REF_CLK,         // Detector reference.
  input logic       O_PFD_FB_CLK,          // Detector feedback.
  input logic       O_PLL_OUT_CLK,         // Divided output.
  input logic       O_CONV_CLK,            // Converter clock.
  input logic       O_LOOP_ENABLE,         // Loop enable.
  input logic       O_PUMP_BIAS_SELF,      // Pump bias.
  input logic [3:0] O_PUMP_CURRENT_LEVEL,  // Pump level.
  input logic [7:0] O_FACTORY_BITS_ENABLE  // Enable register.
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  // Set once the reference divider has been enabled: a later bypass only takes effect at the
  // divider's next wrap, which can be many reference periods away, so the pin is no longer followed at once.
  logic ref_div_used;

  always @(posedge I_CLK) begin
    if (I_RESET) begin
      ref_div_used <= 1'b0;
    end else if (O_FACTORY_BITS_ENABLE[4]) begin
      ref_div_used <= 1'b1;
    end
  end

  // Register fields reach their outputs two edges after the write strobe.
  a_loop_en_write: assert property (
    I_REG_WE && I_REG_ADDR == 8'h59 |-> ##2 O_LOOP_ENABLE == $past(I_REG_WDATA[1], 2))
    else $error("loop enable does not follow write");
  a_pump_bias_write: assert property (
    I_REG_WE && I_REG_ADDR == 8'h58 |-> ##2 O_PUMP_BIAS_SELF == $past(I_REG_WDATA[4], 2))
    else $error("pump bias does not follow write");
  a_pump_level_write: assert property (
    I_REG_WE && I_REG_ADDR == 8'h58 |-> ##2 O_PUMP_CURRENT_LEVEL == $past(I_REG_WDATA[3:0], 2))
    else $error("pump level does not follow write");
  a_unused_bit_write: assert property (
    I_REG_WE && I_REG_ADDR == 8'h59 |-> ##2 O_FACTORY_BITS_ENABLE == {1'b0, $past(I_REG_WDATA[6:0], 2)})
    else $error("enable register image is wrong");
  a_unused_bit_read: assert property (
    I_REG_RE && I_REG_ADDR == 8'h59 |=> O_REG_RDATA[7] == 1'b0)
    else $error("unused enable bit read as one");
  // Two disabled samples leave margin for the gate register.
  a_loop_off_clocks: assert property (
    !O_LOOP_ENABLE ##1 !O_LOOP_ENABLE |-> {O_PFD_REF_CLK, O_PFD_FB_CLK, O_PLL_OUT_CLK} == 3'h0)
    else $error("synthesizer clock active while loop disabled");
  // A level held five samples must have crossed the synchronisers.
  a_ref_bypass_level: assert property (
    (O_LOOP_ENABLE && !ref_div_used && !O_FACTORY_BITS_ENABLE[4] && $stable(I_REF_CLK))[*5]
    |-> O_PFD_REF_CLK == I_REF_CLK)
    else $error("bypassed reference does not follow pin");
  a_conv_ext_level: assert property (
    (!I_TIMING_SRC_PLL && $stable(I_REF_CLK))[*5] |-> O_CONV_CLK == I_REF_CLK)
    else $error("converter clock does not follow pin");

  c_read_enable: cover property (I_REG_RE && I_REG_ADDR == 8'h59);
  c_ref_divided: cover property ($rose(O_PFD_REF_CLK) && O_FACTORY_BITS_ENABLE[4]);
  c_conv_pll: cover property ($rose(O_CONV_CLK) && I_TIMING_SRC_PLL);
endmodule // pdc_top_asserts

bind pdc_top pdc_top_asserts u_chk (
  .I_CLK(I_CLK), .I_RESET(I_RESET), .I_REG_WE(I_REG_WE), .I_REG_RE(I_REG_RE),
  .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
  .I_REF_CLK(I_REF_CLK), .I_VCO_CLK(I_VCO_CLK), .I_TIMING_SRC_PLL(I_TIMING_SRC_PLL),
  .O_PFD_REF_CLK(O_PFD_REF_CLK), .O_PFD_FB_CLK(O_PFD_FB_CLK), .O_PLL_OUT_CLK(O_PLL_OUT_CLK),
  .O_CONV_CLK(O_CONV_CLK), .O_LOOP_ENABLE(O_LOOP_ENABLE), .O_PUMP_BIAS_SELF(O_PUMP_BIAS_SELF),
  .O_PUMP_CURRENT_LEVEL(O_PUMP_CURRENT_LEVEL), .O_FACTORY_BITS_ENABLE(O_FACTORY_BITS_ENABLE));

/* File: pll_divider_config_test.sv */
`timescale 1ns/1ps
`include "pdc_consts.vh"
`define PDC_CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end

module pll_divider_config_test;
  logic I_CLK = 0, I_RESET = 1, I_REG_WE = 0, I_REG_RE = 0, I_REF_CLK = 0, I_VCO_CLK = 0, I_TIMING_SRC_PLL = 0;
  logic [7:0] I_REG_ADDR = 8'h00, I_REG_WDATA = 8'h00;
  wire  [7:0] O_REG_RDATA, O_FACTORY_BITS_ENABLE;
  wire  [3:0] O_PUMP_CURRENT_LEVEL;
  wire        O_PFD_REF_CLK, O_PFD_FB_CLK, O_PLL_OUT_CLK, O_CONV_CLK, O_LOOP_ENABLE, O_PUMP_BIAS_SELF;
  int         mismatches = 0, n_checks = 0, seed = 32'h8c74, ref_cnt = 0, vco_cnt = 0;
  logic [7:0] model [int];
  logic [31:0] d;
  logic [2:0] seen;

  pdc_top uut (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_REG_WE(I_REG_WE), .I_REG_RE(I_REG_RE),
    .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA), .I_REF_CLK(I_REF_CLK),
    .I_VCO_CLK(I_VCO_CLK), .I_TIMING_SRC_PLL(I_TIMING_SRC_PLL), .O_PFD_REF_CLK(O_PFD_REF_CLK),
    .O_PFD_FB_CLK(O_PFD_FB_CLK), .O_PLL_OUT_CLK(O_PLL_OUT_CLK), .O_CONV_CLK(O_CONV_CLK),
    .O_LOOP_ENABLE(O_LOOP_ENABLE), .O_PUMP_BIAS_SELF(O_PUMP_BIAS_SELF),
    .O_PUMP_CURRENT_LEVEL(O_PUMP_CURRENT_LEVEL), .O_FACTORY_BITS_ENABLE(O_FACTORY_BITS_ENABLE));

  always #5 I_CLK = ~I_CLK;

  // Source clocks stay well below the synchroniser limit: reference 12 cycles, oscillator 6.
  always @(negedge I_CLK) begin
    ref_cnt = (ref_cnt + 1) % 6;
    vco_cnt = (vco_cnt + 1) % 3;
    if (ref_cnt == 0) I_REF_CLK = ~I_REF_CLK;
    if (vco_cnt == 0) I_VCO_CLK = ~I_VCO_CLK;
  end

  // One strobe cycle per access; the model keeps what a read must return.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge I_CLK);
    I_REG_WE = 1;
    I_REG_ADDR = a;
    I_REG_WDATA = v;
    @(negedge I_CLK);
    I_REG_WE = 0;
    if (a >= 8'h54 && a <= 8'h59) model[a] = (a == 8'h59) ? (v & 8'h7f) : v;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge I_CLK);
    I_REG_RE = 1;
    I_REG_ADDR = a;
    @(negedge I_CLK);
    I_REG_RE = 0;
    `PDC_CHK("read data", (model.exists(a) ? model[a] : 8'h00), O_REG_RDATA)
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return O_PFD_REF_CLK;
      1: return O_PFD_FB_CLK;
      2: return O_PLL_OUT_CLK;
      default: return O_CONV_CLK;
    endcase
  endfunction

  // New ratios wait for a wrap, so the early rises are skipped and the period from the third to the fourth rise is timed.
  task automatic per(input int s, input int ex);
    int r = 0;
    int t = 0;
    int t2 = 0;
    logic p;
    p = pick(s);
    for (int c = 0; c < 60000 && r < 4; c++) begin
      @(negedge I_CLK);
      if (pick(s) && !p) begin
        r++;
        t2 = t;
        t = c;
      end
      p = pick(s);
    end
    `PDC_CHK("clock rises", 4, r)
    `PDC_CHK("clock period", ex, t - t2)
  endtask

  task final_report;
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #1000000;
    mismatches++;
    final_report;
  end

  initial begin
    model[8'h54] = 8'h00;
    model[8'h55] = 8'h48;
    model[8'h56] = 8'h78;
    model[8'h57] = 8'h40;
    model[8'h58] = 8'h12;
    model[8'h59] = 8'h41;
    repeat (12) @(posedge I_CLK);
    @(negedge I_CLK);
    I_RESET = 0;
    for (int a = 8'h54; a <= 8'h59; a++) rd(a[7:0]);
    `PDC_CHK("loop enable", 1'b0, O_LOOP_ENABLE)
    `PDC_CHK("pump bias", model[8'h58][4], O_PUMP_BIAS_SELF)
    `PDC_CHK("pump level", model[8'h58][3:0], O_PUMP_CURRENT_LEVEL)
    rd(8'h53);
    wr(8'h5a, 8'hff);
    rd(8'h5a);
    // Random user fields; factory bits of the pump register are kept at zero.
    repeat (8) begin
      d = $random(seed);
      wr(8'h58, {3'b000, d[4:0]});
      @(negedge I_CLK);
      `PDC_CHK("pump bias", d[4], O_PUMP_BIAS_SELF)
      `PDC_CHK("pump level", d[3:0], O_PUMP_CURRENT_LEVEL)
      rd(8'h58);
      wr(8'h54, (d[15:8] == 8'h02) ? 8'h03 : d[15:8]);
      rd(8'h54);
    end
    wr(8'h59, 8'hc3);
    rd(8'h59);
    `PDC_CHK("enable image", model[8'h59], O_FACTORY_BITS_ENABLE)
    `PDC_CHK("loop enable", 1'b1, O_LOOP_ENABLE)
    per(0, 12);
    per(1, 720);
    per(2, 24);
    @(negedge I_CLK) I_TIMING_SRC_PLL = 1;
    per(3, 24);
    @(negedge I_CLK) I_TIMING_SRC_PLL = 0;
    per(3, 12);
    wr(8'h54, 8'h03);
    wr(8'h59, 8'h53);
    per(0, 36);
    wr(8'h54, 8'h00);
    per(0, 12);
    wr(8'h55, 8'h49);
    wr(8'h54, 8'h03);
    per(0, 3108);
    wr(8'h54, 8'hff);
    wr(8'h55, 8'h4b);
    per(0, 12276);
    wr(8'h55, 8'hfb);
    per(2, 90);
    wr(8'h55, 8'h2b);
    per(2, 12);
    wr(8'h55, 8'h0b);
    per(2, 6);
    wr(8'h57, 8'h41);
    wr(8'h56, 8'h02);
    per(1, 1548);
    wr(8'h57, 8'h40);
    per(1, 12);
    wr(8'h56, 8'h01);
    per(1, 6);
    // Clearing the loop enable must silence all three synthesizer clocks.
    wr(8'h59, 8'h51);
    repeat (3) @(negedge I_CLK);
    seen = 3'h0;
    repeat (100) begin
      @(negedge I_CLK);
      seen = seen | {O_PFD_REF_CLK, O_PFD_FB_CLK, O_PLL_OUT_CLK};
    end
    `PDC_CHK("gated clocks", 3'h0, seen)
    final_report;
  end
endmodule // pll_divider_config_test
